// File: design/leid_decoder.sv
// Extended instruction decoder for a character LCD controller, AXI4-Lite slave
// Overview of operation
// RULE1: With the extension bit set, command 00001xxx loads font width, cursor inversion and four-line mode within 39us.
// RULE2: Font width one renders characters 6 dots wide, zero renders them 5 dots wide.
// RULE3: Cursor inversion one shows the cursor by inverting the cell, zero disables that.
// RULE4: Four-line mode one drives four lines, zero uses one or two lines per the line-count bit.
// RULE5: With the extension bit clear, command 0001xxxx shifts the display (bit 3 one) or the cursor (zero), ignoring bits 1..0, in 39us.
// RULE6: For that shift, bit 2 one shifts right and zero shifts left.
// RULE7: Extension set and shift/scroll select one, command 0001xxxx loads per-line shift enables, bit 0 is line 1.
// RULE8: Extension set and shift/scroll select zero, the same code loads per-line dot-scroll enables instead.
// RULE9: While an instruction executes, a busy-flag read returns bit 7 high.
// RULE10: The host polls the busy flag and waits for it low before the next instruction.
// RULE11: After seeing busy low the host allows half an oscillator period before the next instruction.
// RULE12: The function set command writes the extension bit together with data length and line count.
// RULE13: Function set with the extension bit clear writes shift/scroll select, one for shift, zero for scroll.
`timescale 1ns/1ps
`default_nettype none
`include "leid_regs.svh"

module leid_decoder
  import leid_pkg::*;
#(
  parameter int EXEC_CYCLES = `LEID_EXEC_TIME_NS / `LEID_CLK_PERIOD_NS
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic busy_indicator_o,
  output logic font_width_sel_o,
  output logic [2:0] char_width_o,
  output logic cursor_invert_o,
  output logic four_line_mode_o,
  output logic [2:0] display_lines_o,
  output logic [3:0] line_shift_en_o,
  output logic [3:0] line_dot_scroll_en_o,
  output logic shift_pulse_o,
  output logic shift_display_o,
  output logic shift_right_o
);

  // ************************************************************
  // Helpers
  // ************************************************************
  localparam logic [`LEID_CNT_W-1:0] EXEC_CNT = EXEC_CYCLES[`LEID_CNT_W-1:0];

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a[7:2] == ofs[7:2]);
  endfunction : is_reg

  function automatic logic [31:0] rd_mux(input leid_state_s st, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (is_reg(a, `LEID_CMD_OFS)) begin
      d[7:0] = st.last_code;
    end else if (is_reg(a, `LEID_STAT_OFS)) begin
      d[`LEID_STAT_BUSY_BIT] = st.busy; // [RULE9]
    end else if (is_reg(a, `LEID_CFG_OFS)) begin
      d[`LEID_CFG_FW_BIT] = st.fw;
      d[`LEID_CFG_BW_BIT] = st.bw;
      d[`LEID_CFG_NW_BIT] = st.nw;
      d[`LEID_CFG_EXT_BIT] = st.ext;
      d[`LEID_CFG_DH_BIT] = st.dh;
      d[`LEID_CFG_DL_BIT] = st.dl;
      d[`LEID_CFG_N_BIT] = st.nl;
      d[11:8] = st.sh_en;
      d[15:12] = st.sc_en;
    end else if (is_reg(a, `LEID_SHIFT_OFS)) begin
      d[0] = st.shd;
      d[1] = st.shr;
      d[15:8] = st.shcnt;
    end
    rd_mux = d;
  endfunction : rd_mux

  function automatic logic mapped(input logic [7:0] a);
    mapped = is_reg(a, `LEID_CMD_OFS) || is_reg(a, `LEID_STAT_OFS) ||
             is_reg(a, `LEID_CFG_OFS) || is_reg(a, `LEID_SHIFT_OFS);
  endfunction : mapped

  // ************************************************************
  // State
  // ************************************************************
  leid_state_s s_ff;
  leid_state_s nxt_s;
  logic wr_go;
  logic cmd_go;
  logic [7:0] code;

  assign wr_go = s_ff.aw_got && s_ff.w_got;
  assign code = s_ff.wdata[7:0];
  // Data writes and writes while busy are dropped; host must poll first
  assign cmd_go = wr_go && is_reg(s_ff.waddr, `LEID_CMD_OFS) && s_ff.wstrb[0] &&
                  !(s_ff.wstrb[1] && s_ff.wdata[`LEID_CMD_CDS_BIT]) && !s_ff.busy; // [RULE10]

  always_comb begin
    nxt_s = s_ff;
    nxt_s.shp = 1'b0;
    // Write channels taken independently, in either order
    if (s_axi_awvalid_i && s_ff.awrdy) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.waddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_ff.wrdy) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = s_axi_wdata_i;
      nxt_s.wstrb = s_axi_wstrb_i;
    end
    if (s_ff.bvalid && s_axi_bready_i) begin
      nxt_s.bvalid = 1'b0;
    end
    // Execution timer
    if (s_ff.busy) begin
      nxt_s.cnt = s_ff.cnt - 1'b1;
      if (s_ff.cnt == 1) begin
        nxt_s.busy = 1'b0;
      end
    end
    if (wr_go) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = mapped(s_ff.waddr) ? `LEID_RESP_OKAY : `LEID_RESP_SLVERR;
    end
    if (cmd_go) begin
      nxt_s.last_code = code;
      nxt_s.busy = 1'b1; // [RULE9]
      nxt_s.cnt = EXEC_CNT; // [RULE1] [RULE5]
      if (code[7:5] == 3'h1) begin
        nxt_s.dl = code[4]; // [RULE12]
        nxt_s.nl = code[3];
        nxt_s.ext = code[2];
        if (!code[2]) begin
          nxt_s.dh = code[1]; // [RULE13]
        end
      end else if (s_ff.ext && code[7:3] == 5'h01) begin
        nxt_s.fw = code[2]; // [RULE1]
        nxt_s.bw = code[1];
        nxt_s.nw = code[0];
      end else if (code[7:4] == 4'h1) begin
        if (!s_ff.ext) begin
          nxt_s.shp = 1'b1; // [RULE5]
          nxt_s.shd = code[3];
          nxt_s.shr = code[2]; // [RULE6]
          nxt_s.shcnt = s_ff.shcnt + 8'h01;
        end else if (s_ff.dh) begin
          nxt_s.sh_en = code[3:0]; // [RULE7]
        end else begin
          nxt_s.sc_en = code[3:0]; // [RULE8]
        end
      end
    end
    // Read channel
    if (s_ff.rvalid && s_axi_rready_i) begin
      nxt_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && s_ff.arrdy) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = rd_mux(s_ff, s_axi_araddr_i);
      nxt_s.rresp = mapped(s_axi_araddr_i) ? `LEID_RESP_OKAY : `LEID_RESP_SLVERR;
    end
    nxt_s.awrdy = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wrdy = !nxt_s.w_got && !nxt_s.bvalid;
    nxt_s.arrdy = !nxt_s.rvalid;
    // Derived display settings, kept in flops so outputs are clean
    nxt_s.cw = nxt_s.fw ? `LEID_CW_6 : `LEID_CW_5; // [RULE2]
    nxt_s.lines = nxt_s.nw ? `LEID_LINES_4 : // [RULE4]
                  (nxt_s.nl ? `LEID_LINES_2 : `LEID_LINES_1);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s_ff <= '0;
      s_ff.cw <= `LEID_CW_5;
      s_ff.lines <= `LEID_LINES_1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_awready_o = s_ff.awrdy;
  assign s_axi_wready_o = s_ff.wrdy;
  assign s_axi_bresp_o = s_ff.bresp;
  assign s_axi_bvalid_o = s_ff.bvalid;
  assign s_axi_arready_o = s_ff.arrdy;
  assign s_axi_rdata_o = s_ff.rdata;
  assign s_axi_rresp_o = s_ff.rresp;
  assign s_axi_rvalid_o = s_ff.rvalid;
  assign busy_indicator_o = s_ff.busy;
  assign font_width_sel_o = s_ff.fw;
  assign char_width_o = s_ff.cw;
  assign cursor_invert_o = s_ff.bw; // [RULE3]
  assign four_line_mode_o = s_ff.nw;
  assign display_lines_o = s_ff.lines;
  assign line_shift_en_o = s_ff.sh_en;
  assign line_dot_scroll_en_o = s_ff.sc_en;
  assign shift_pulse_o = s_ff.shp;
  assign shift_display_o = s_ff.shd;
  assign shift_right_o = s_ff.shr;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  ext_func_load_a: assert property ( // [RULE1]
    cmd_go && s_ff.ext && code[7:3] == 5'h01 |=> font_width_sel_o == $past(code[2]) &&
      cursor_invert_o == $past(code[1]) && four_line_mode_o == $past(code[0]) && busy_indicator_o)
    else $error("extended function set not loaded");

  char_width_a: assert property ( // [RULE2]
    cmd_go && s_ff.ext && code[7:3] == 5'h01 |=>
      char_width_o == ($past(code[2]) ? 3'h6 : 3'h5))
    else $error("character width does not follow font width");

  cursor_inv_a: assert property ( // [RULE3]
    cmd_go && s_ff.ext && code[7:3] == 5'h01 && code[1] |=> ##[0:3] cursor_invert_o)
    else $error("cursor inversion not enabled");

  line_mode_a: assert property ( // [RULE4]
    cmd_go && s_ff.ext && code[7:3] == 5'h01 |=>
      display_lines_o == ($past(code[0]) ? 3'h4 : (s_ff.nl ? 3'h2 : 3'h1)))
    else $error("display line count wrong");

  shift_cmd_a: assert property ( // [RULE5]
    cmd_go && !s_ff.ext && code[7:4] == 4'h1 |=> shift_pulse_o &&
      shift_display_o == $past(code[3]) ##1 !shift_pulse_o)
    else $error("shift command not performed");

  shift_dir_a: assert property ( // [RULE6]
    $rose(shift_pulse_o) |-> shift_right_o == $past(code[2]))
    else $error("shift direction wrong");

  shift_en_a: assert property ( // [RULE7]
    cmd_go && s_ff.ext && s_ff.dh && code[7:4] == 4'h1 |=> line_shift_en_o == $past(code[3:0])
      && $stable(line_dot_scroll_en_o))
    else $error("line shift enables not loaded");

  scroll_en_a: assert property ( // [RULE8]
    cmd_go && s_ff.ext && !s_ff.dh && code[7:4] == 4'h1 |=>
      line_dot_scroll_en_o == $past(code[3:0]) && $stable(line_shift_en_o))
    else $error("dot scroll enables not loaded");

  busy_read_a: assert property ( // [RULE9]
    s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i[7:2] == 6'h01 && busy_indicator_o
      |=> s_axi_rvalid_o && s_axi_rdata_o[7])
    else $error("busy flag read low while executing");

  busy_length_a: assert property ( // [RULE9]
    $fell(busy_indicator_o) |-> $past(s_ff.cnt) == 1)
    else $error("busy dropped before execution time");

  func_set_a: assert property ( // [RULE12] [RULE13]
    cmd_go && code[7:5] == 3'h1 && !code[2] |=> !s_ff.ext && s_ff.dh == $past(code[1]))
    else $error("function set bits not stored");

  // Pair is registered first, so the response stands two edges after the take
  write_resp_a: assert property (
    s_axi_awready_o && s_axi_awvalid_i && s_axi_wready_o && s_axi_wvalid_i |=> ##1
      s_axi_bvalid_o)
    else $error("write response late");

  busy_start_a: assert property ( // [RULE9]
    $rose(busy_indicator_o) |-> $past(cmd_go) && s_ff.cnt == EXEC_CNT)
    else $error("busy raised without an accepted command");

  pulse_width_a: assert property ( // [RULE5]
    shift_pulse_o |=> !shift_pulse_o)
    else $error("shift pulse longer than one cycle");

  shift_keep_a: assert property ( // [RULE6]
    cmd_go && !s_ff.ext && code[7:4] == 4'h1 |=> shift_right_o == $past(code[2]) &&
      $stable(line_shift_en_o) && $stable(line_dot_scroll_en_o))
    else $error("shift command changed line enables");

  ext_set_a: assert property ( // [RULE12] [RULE13]
    cmd_go && code[7:5] == 3'h1 && code[2] |=> s_ff.ext && s_ff.nl == $past(code[3]) &&
      $stable(s_ff.dh))
    else $error("function set with extension not stored");

  ext_gate_a: assert property ( // [RULE1]
    cmd_go && !s_ff.ext && code[7:3] == 5'h01 |=> $stable(font_width_sel_o) &&
      $stable(cursor_invert_o) && $stable(four_line_mode_o))
    else $error("extended function set acted in base set");

  // Data writes belong to the RAM path, which this block does not model
  data_ignore_a: assert property ( // [RULE1]
    wr_go && s_ff.wstrb[1] && s_ff.wdata[`LEID_CMD_CDS_BIT] |=> $stable(s_ff.last_code) &&
      !$rose(busy_indicator_o))
    else $error("data write taken as a command");

endmodule : leid_decoder
`default_nettype wire

// File: design/leid_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef LEID_REGS_SVH
`define LEID_REGS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define LEID_CMD_OFS 8'h00
`define LEID_STAT_OFS 8'h04
`define LEID_CFG_OFS 8'h08
`define LEID_SHIFT_OFS 8'h0C

// ************************************************************
// Field positions
// ************************************************************
`define LEID_CMD_CDS_BIT 8
`define LEID_STAT_BUSY_BIT 7
`define LEID_CFG_FW_BIT 0
`define LEID_CFG_BW_BIT 1
`define LEID_CFG_NW_BIT 2
`define LEID_CFG_EXT_BIT 3
`define LEID_CFG_DH_BIT 4
`define LEID_CFG_DL_BIT 5
`define LEID_CFG_N_BIT 6

// ************************************************************
// Reset values and encodings
// ************************************************************
`define LEID_CW_5 3'h5
`define LEID_CW_6 3'h6
`define LEID_LINES_1 3'h1
`define LEID_LINES_2 3'h2
`define LEID_LINES_4 3'h4
`define LEID_RESP_OKAY 2'h0
`define LEID_RESP_SLVERR 2'h2

// ************************************************************
// Timing
// ************************************************************
`define LEID_CLK_PERIOD_NS 8
`define LEID_EXEC_TIME_NS 39000
`define LEID_CNT_W 16

`endif

// File: design/leid_pkg.sv
// Types shared by the extended instruction decoder
`default_nettype none
`include "leid_regs.svh"

package leid_pkg;

  typedef struct packed {
    logic awrdy;
    logic wrdy;
    logic aw_got;
    logic w_got;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arrdy;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic busy;
    logic [`LEID_CNT_W-1:0] cnt;
    logic ext;
    logic dh;
    logic dl;
    logic nl;
    logic fw;
    logic bw;
    logic nw;
    logic [3:0] sh_en;
    logic [3:0] sc_en;
    logic shp;
    logic shd;
    logic shr;
    logic [7:0] shcnt;
    logic [7:0] last_code;
    logic [2:0] cw;
    logic [2:0] lines;
  } leid_state_s;

endpackage : leid_pkg
`default_nettype wire

// File: dv/leid_host.sv
// Host model: AXI4-Lite master that polls the busy flag
`timescale 1ns/1ps
`default_nettype none
`include "leid_regs.svh"
module leid_host #(
  parameter int HALF_OSC = 4
) (
  input wire logic mclk_i,
  output logic [7:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  output logic [7:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  // ************************************************************
  // Bus cycles
  // ************************************************************
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wstrb_o <= 4'hF;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    forever begin
      @(posedge mclk_i);
      // Released payload flips so stale values never pass
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o <= ~a;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o <= ~d;
      end
      if (bvalid_i) begin
        r = bresp_i;
        bready_o <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    forever begin
      @(posedge mclk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o <= ~a;
      end
      if (rvalid_i) begin
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        break;
      end
    end
  endtask : rd

  task automatic wait_idle();
    logic [31:0] d;
    logic [1:0] r;
    d = 32'h80;
    while (d[7] !== 1'b0) rd(`LEID_STAT_OFS, d, r);
    repeat (HALF_OSC) @(posedge mclk_i);
  endtask : wait_idle
endmodule : leid_host
`default_nettype wire

// File: dv/lcd_ext_instruction_decoder_test.sv
// Self-checking bench for the extended instruction decoder
`timescale 1ns/1ps
`default_nettype none
`include "leid_regs.svh"
module lcd_ext_instruction_decoder_test;
  import leid_pkg::*;
  // ************************************************************
  // Wiring
  // ************************************************************
  localparam int EXEC = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire logic [7:0] aw, ar;
  wire logic [31:0] wd, rdat;
  wire logic [3:0] ws, shen, scen;
  wire logic [1:0] bresp, rresp;
  wire logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  wire logic busy, fws, inv, nw, pulse, sdisp, sright;
  wire logic [2:0] cw, lines;
  int num_errors, compares, pulses, busy_len, busy_run, cycles;

  initial forever #4 clk = ~clk;

  leid_decoder #(.EXEC_CYCLES(EXEC)) leid_decoder_inst (.mclk_i(clk), .reset_i(rst),
    .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
    .s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
    .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr),
    .busy_indicator_o(busy), .font_width_sel_o(fws), .char_width_o(cw),
    .cursor_invert_o(inv), .four_line_mode_o(nw), .display_lines_o(lines),
    .line_shift_en_o(shen), .line_dot_scroll_en_o(scen), .shift_pulse_o(pulse),
    .shift_display_o(sdisp), .shift_right_o(sright));

  leid_host #(.HALF_OSC(4)) leid_host_inst (.mclk_i(clk), .awaddr_o(aw), .awvalid_o(awv),
    .awready_i(awr), .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wr),
    .bresp_i(bresp), .bvalid_i(bv), .bready_o(br), .araddr_o(ar), .arvalid_o(arv),
    .arready_i(arr), .rdata_i(rdat), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr));

  // ************************************************************
  // Checking helpers
  // ************************************************************
  always @(posedge clk) begin
    cycles++;
    if (pulse === 1'b1) pulses++;
    if (busy === 1'b1) busy_run++;
    else if (busy_run != 0) begin
      busy_len = busy_run;
      busy_run = 0;
    end
    // Whole run needs about 900 cycles
    if (cycles == 6000) begin
      num_errors++;
      end_sim();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cmd(input logic [7:0] c);
    logic [1:0] r;
    logic [31:0] d;
    leid_host_inst.wr(`LEID_CMD_OFS, {24'h0, c}, r);
    chk("bresp", 32'h0, {30'h0, r});
    leid_host_inst.rd(`LEID_STAT_OFS, d, r);
    chk("busy", 32'h80, d & 32'h80);
    leid_host_inst.wait_idle();
    chk("busy_len", EXEC, busy_len);
  endtask : cmd

  function automatic logic [2:0] exp_lines(input logic four, input logic two);
    return four ? `LEID_LINES_4 : (two ? `LEID_LINES_2 : `LEID_LINES_1);
  endfunction : exp_lines

  task automatic end_sim();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim

  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    logic [7:0] c;
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] esh, esc;
    logic n;
    int p;
    void'($urandom(32'h1AC5F1F9));
    esh = 4'h0;
    esc = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("cw", `LEID_CW_5, cw);
    chk("lines", `LEID_LINES_1, lines);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      n = 1'($urandom);
      cmd({4'h3, n, 3'b100});
      cmd({5'h01, i[2:0]});
      chk("fw", i[2], fws);
      chk("cw", i[2] ? `LEID_CW_6 : `LEID_CW_5, cw);
      chk("inv", i[1], inv);
      chk("nw", i[0], nw);
      chk("lines", exp_lines(i[0], n), lines);
    end
    // Same code with the base set is display control, not a font change
    cmd(8'h30);
    cmd(8'h08);
    chk("fw", 1'b1, fws);
    $display("test ext_fset done");
    for (int i = 0; i < 8; i++) begin
      c = {4'h1, 4'($urandom)};
      cmd({6'h0C, i[0], 1'b0});
      cmd(8'h34);
      cmd(c);
      if (i[0]) esh = c[3:0];
      else esc = c[3:0];
      chk("shen", esh, shen);
      chk("scen", esc, scen);
    end
    leid_host_inst.rd(`LEID_CFG_OFS, d, r);
    chk("cfg", {esc, esh}, d[15:8]);
    $display("test enables done");
    cmd(8'h30);
    for (int i = 0; i < 8; i++) begin
      c = {4'h1, i[1:0], 2'($urandom)};
      p = pulses;
      cmd(c);
      chk("pulse", p + 1, pulses);
      chk("target", c[3], sdisp);
      chk("dir", c[2], sright);
    end
    chk("shen", esh, shen);
    leid_host_inst.rd(`LEID_SHIFT_OFS, d, r);
    chk("shcnt", 32'h8, d[15:8]);
    $display("test shift done");
    leid_host_inst.wr(8'h10, 32'h0, r);
    chk("bresp", `LEID_RESP_SLVERR, r);
    leid_host_inst.rd(8'h3C, d, r);
    chk("rresp", `LEID_RESP_SLVERR, r);
    chk("rdata", 32'h0, d);
    // Data write carrying a function set code must leave the set untouched
    leid_host_inst.wr(`LEID_CMD_OFS, 32'h0000_0134, r);
    chk("bresp", `LEID_RESP_OKAY, r);
    leid_host_inst.rd(`LEID_CFG_OFS, d, r);
    chk("ext", 32'h0, d[`LEID_CFG_EXT_BIT]);
    $display("test unmapped done");
    end_sim();
  end
endmodule : lcd_ext_instruction_decoder_test
`default_nettype wire
